// *** logic/tpw_map.vh ***
// Register offsets, field positions, reset values and constants of the PWM timer
`ifndef TPW_MAP_VH
`define TPW_MAP_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define TPW_CTRL_OFF     12'h000
`define TPW_CMPA_OFF     12'h004
`define TPW_CMPB_OFF     12'h008
`define TPW_CAPT_OFF     12'h00C
`define TPW_CNT_OFF      12'h010
`define TPW_FLAG_OFF     12'h014
`define TPW_CMPA_ACT_OFF 12'h018

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define TPW_CTRL_MODE_LSB 0
`define TPW_CTRL_MODE_MSB 3
`define TPW_CTRL_OMA_LSB  4
`define TPW_CTRL_OMA_MSB  5
`define TPW_CTRL_OMB_LSB  6
`define TPW_CTRL_OMB_MSB  7
`define TPW_CTRL_PRE_LSB  8
`define TPW_CTRL_PRE_MSB  10
`define TPW_CTRL_DIRA_BIT 11
`define TPW_CTRL_DIRB_BIT 12
`define TPW_CTRL_RESET    32'h00000000

// ------------------------------------------------------------------
// Flag register bits (write one to clear)
// ------------------------------------------------------------------
`define TPW_FLAG_OVF_BIT  0
`define TPW_FLAG_CMPA_BIT 1
`define TPW_FLAG_CMPB_BIT 2
`define TPW_FLAG_CAPT_BIT 3

// ------------------------------------------------------------------
// Counting constants
// ------------------------------------------------------------------
`define TPW_BOTTOM   16'h0000
`define TPW_MAX      16'hFFFF
`define TPW_TOP_8B   16'h00FF
`define TPW_TOP_9B   16'h01FF
`define TPW_TOP_10B  16'h03FF

// Output mode field codes
`define TPW_OM_OFF    2'h0
`define TPW_OM_TOGGLE 2'h1
`define TPW_OM_NONINV 2'h2
`define TPW_OM_INV    2'h3

// Prescaler select codes: 0 stop, 1..5 = /1 /8 /64 /256 /1024
`define TPW_PRE_STOP  3'h0
`define TPW_PRE_DIV1  3'h1
`define TPW_PRE_DIV8  3'h2
`define TPW_PRE_DIV64 3'h3
`define TPW_PRE_D256  3'h4
`define TPW_PRE_D1024 3'h5

`endif

// *** logic/tpw_prescaler.v ***
// Prescaler that makes the timer clock enable from the I/O clock
`timescale 1ns/1ns
`include "tpw_map.vh"

module tpw_prescaler (
   input  wire       clk,
   input  wire       nrst,
   input  wire [2:0] sel,
   output reg        tick
);

   reg [9:0] div_q;

   // ------------------------------------------------------------------
   // Free-running divider and enable pulse selection
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         div_q <= 10'h000;
         tick  <= 1'b0;
      end else begin
         div_q <= div_q + 10'h001;
         case (sel)
            `TPW_PRE_DIV1:  tick <= 1'b1;
            `TPW_PRE_DIV8:  tick <= (div_q[2:0] == 3'h7);
            `TPW_PRE_DIV64: tick <= (div_q[5:0] == 6'h3F);
            `TPW_PRE_D256:  tick <= (div_q[7:0] == 8'hFF);
            `TPW_PRE_D1024: tick <= (div_q == 10'h3FF);
            default:        tick <= 1'b0;
         endcase
      end
   end

endmodule // tpw_prescaler

// *** logic/tpw_timer.v ***
// PWM waveform generator of a 16-bit timer with an APB register slave
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "tpw_map.vh"

module tpw_timer (
   input  wire        REF_CLK,
   input  wire        NRST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   output reg         COMPARE_OUTPUT_A,
   output reg         COMPARE_OUTPUT_B,
   output reg         PIN_ENABLE_A_N,
   output reg         PIN_ENABLE_B_N
);

   // ------------------------------------------------------------------
   // Mode decoding helpers
   // ------------------------------------------------------------------
   function is_fast;
      input [3:0] m;
      is_fast = (m == 4'd5) || (m == 4'd6) || (m == 4'd7) || (m == 4'd14) || (m == 4'd15);
   endfunction

   function is_phase;
      input [3:0] m;
      is_phase = (m == 4'd1) || (m == 4'd2) || (m == 4'd3) || (m == 4'd10) || (m == 4'd11);
   endfunction

   function is_freq;
      input [3:0] m;
      is_freq = (m == 4'd8) || (m == 4'd9);
   endfunction

   // Resolution mask for fixed TOP modes; all ones otherwise
   function [15:0] res_mask;
      input [3:0] m;
      case (m)
         4'd1, 4'd5: res_mask = `TPW_TOP_8B;
         4'd2, 4'd6: res_mask = `TPW_TOP_9B;
         4'd3, 4'd7: res_mask = `TPW_TOP_10B;
         default:    res_mask = `TPW_MAX;
      endcase
   endfunction

   // Level a dual-slope match drives for the given slope and output mode
   function dual_level;
      input       dn;
      input [1:0] om;
      dual_level = dn ^ (om == `TPW_OM_INV);
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   reg  [31:0] ctrl_q;
   reg  [15:0] cmpa_buf_q;
   reg  [15:0] cmpb_buf_q;
   reg  [15:0] cmpa_q;
   reg  [15:0] cmpb_q;
   reg  [15:0] capt_q;
   reg  [15:0] cnt_q;
   reg         down_q;
   reg  [3:0]  flag_q;
   reg         oca_q;
   reg         ocb_q;
   reg  [3:0]  flag_d;
   reg  [15:0] top;
   reg         top_src_a;
   reg         top_src_c;
   reg  [31:0] rd_d;
   wire        tick;

   wire [3:0]  mode   = ctrl_q[`TPW_CTRL_MODE_MSB:`TPW_CTRL_MODE_LSB];
   wire [1:0]  om_a   = ctrl_q[`TPW_CTRL_OMA_MSB:`TPW_CTRL_OMA_LSB];
   wire [1:0]  om_b   = ctrl_q[`TPW_CTRL_OMB_MSB:`TPW_CTRL_OMB_LSB];
   wire        fast   = is_fast(mode);
   wire        phase  = is_phase(mode);
   wire        freq   = is_freq(mode);
   wire        dual   = phase | freq;
   wire        wr_acc = PSEL & PENABLE & PWRITE & PREADY;
   wire        rd_set = PSEL & !PENABLE & !PWRITE;
   wire        mapped = (PADDR <= `TPW_CMPA_ACT_OFF) && (PADDR[1:0] == 2'h0);

   // ------------------------------------------------------------------
   // Timer clock enable
   // ------------------------------------------------------------------
   tpw_prescaler u_pre (
      .clk  (REF_CLK),
      .nrst (NRST),
      .sel  (ctrl_q[`TPW_CTRL_PRE_MSB:`TPW_CTRL_PRE_LSB]),
      .tick (tick)
   );

   // ------------------------------------------------------------------
   // TOP selection per mode
   // ------------------------------------------------------------------
   // Fixed TOP follows the resolution mask, a register sets it in modes 8 to 11, 14 and 15, and other modes count to MAX
   always @* begin
      top       = `TPW_MAX;
      top_src_a = 1'b0;
      top_src_c = 1'b0;
      case (mode)
         4'd1, 4'd2, 4'd3, 4'd5, 4'd6, 4'd7: top = res_mask(mode);
         4'd8, 4'd10, 4'd14: begin
            top       = capt_q;
            top_src_c = 1'b1;
         end
         4'd9, 4'd11, 4'd15: begin
            top       = cmpa_q;
            top_src_a = 1'b1;
         end
         default: top = `TPW_MAX;
      endcase
   end

   // Match terms; a compare above TOP is never reached
   wire at_top  = (cnt_q == top);
   wire at_bot  = (cnt_q == `TPW_BOTTOM);
   wire match_a = (cnt_q == cmpa_q) && (cmpa_q <= top);
   wire match_b = (cnt_q == cmpb_q) && (cmpb_q <= top);
   // Load point of the double buffers
   wire load_pt = (fast & at_top) | (phase & at_top) | (freq & at_bot & down_q);
   // Slope seen by a dual-slope match: TOP counts as falling and BOTTOM as rising,
   // so in non-inverted mode a compare at BOTTOM stays low and a compare at TOP stays high
   wire slope_dn = at_top | (down_q & !at_bot);

   // ------------------------------------------------------------------
   // Counter and direction
   // ------------------------------------------------------------------
   // A software write to the counter wins over the timer clock enable
   always @(posedge REF_CLK) begin
      if (!NRST) begin
         cnt_q  <= 16'h0000;
         down_q <= 1'b0;
      end else if (wr_acc && PADDR == `TPW_CNT_OFF) begin
         cnt_q <= PWDATA[15:0];
      end else if (tick) begin
         if (fast) begin
            cnt_q <= at_top ? `TPW_BOTTOM : cnt_q + 16'h0001;
         end else if (dual) begin
            if (!down_q) begin
               if (at_top) begin
                  down_q <= 1'b1;
                  cnt_q  <= cnt_q - 16'h0001;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end else if (at_bot) begin
               down_q <= 1'b0;
               cnt_q  <= cnt_q + 16'h0001;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end else begin
            cnt_q  <= cnt_q + 16'h0001;
            down_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Double-buffered compare values
   // ------------------------------------------------------------------
   // Non-PWM modes take a written compare at the next timer clock
   always @(posedge REF_CLK) begin
      if (!NRST) begin
         cmpa_q <= 16'h0000;
         cmpb_q <= 16'h0000;
      end else if (tick && (load_pt || !(fast || dual))) begin
         cmpa_q <= cmpa_buf_q;
         cmpb_q <= cmpb_buf_q;
      end
   end

   // ------------------------------------------------------------------
   // Flags: hardware set wins over software clear
   // ------------------------------------------------------------------
   // The clear is applied first so that a set in the same cycle overrides it
   always @* begin
      flag_d = flag_q;
      if (wr_acc && PADDR == `TPW_FLAG_OFF)
         flag_d = flag_q & ~PWDATA[3:0];
      if (tick) begin
         if ((fast & at_top) | (phase & at_bot & down_q) | (freq & at_bot & down_q))
            flag_d[`TPW_FLAG_OVF_BIT] = 1'b1;
         if (match_a | (load_pt & top_src_a))
            flag_d[`TPW_FLAG_CMPA_BIT] = 1'b1;
         if (match_b)
            flag_d[`TPW_FLAG_CMPB_BIT] = 1'b1;
         if ((fast | phase) & at_top & top_src_c)
            flag_d[`TPW_FLAG_CAPT_BIT] = 1'b1;
         else if (freq & at_top & top_src_c & !down_q)
            flag_d[`TPW_FLAG_CAPT_BIT] = 1'b1;
      end
   end

   always @(posedge REF_CLK) begin
      if (!NRST)
         flag_q <= 4'h0;
      else
         flag_q <= flag_d;
   end

   // ------------------------------------------------------------------
   // Waveform generation per channel
   // ------------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (!NRST) begin
         oca_q <= 1'b0;
         ocb_q <= 1'b0;
      end else if (tick) begin
         if (fast) begin
            // Match wins over wrap so compare at TOP stays constant
            if (om_a[1]) begin
               if (match_a)
                  oca_q <= (om_a == `TPW_OM_NONINV);
               else if (at_top)
                  oca_q <= (om_a == `TPW_OM_INV);
            end else if (om_a == `TPW_OM_TOGGLE && mode == 4'd15 && match_a) begin
               oca_q <= !oca_q;
            end
            if (om_b[1]) begin
               if (match_b)
                  ocb_q <= (om_b == `TPW_OM_NONINV);
               else if (at_top)
                  ocb_q <= (om_b == `TPW_OM_INV);
            end
         end else if (dual) begin
            // Up-match clears, down-match sets for non-inverted
            if (om_a[1] && match_a)
               oca_q <= dual_level(slope_dn, om_a);
            else if (om_a == `TPW_OM_TOGGLE && (mode == 4'd11 || mode == 4'd9) && match_a)
               oca_q <= !oca_q;
            if (om_b[1] && match_b)
               ocb_q <= dual_level(slope_dn, om_b);
         end
      end
   end

   // ------------------------------------------------------------------
   // Pins: level and active-low drive enable gated by direction
   // ------------------------------------------------------------------
   // Both the direction bit and a live output mode are needed to drive a pin
   always @(posedge REF_CLK) begin
      if (!NRST) begin
         COMPARE_OUTPUT_A <= 1'b0;
         COMPARE_OUTPUT_B <= 1'b0;
         PIN_ENABLE_A_N   <= 1'b1;
         PIN_ENABLE_B_N   <= 1'b1;
      end else begin
         COMPARE_OUTPUT_A <= oca_q;
         COMPARE_OUTPUT_B <= ocb_q;
         PIN_ENABLE_A_N   <= !(ctrl_q[`TPW_CTRL_DIRA_BIT] && om_a != `TPW_OM_OFF);
         PIN_ENABLE_B_N   <= !(ctrl_q[`TPW_CTRL_DIRB_BIT] && om_b != `TPW_OM_OFF);
      end
   end

   // ------------------------------------------------------------------
   // APB register writes
   // ------------------------------------------------------------------
   // Compare writes are masked by the resolution of the mode in force
   always @(posedge REF_CLK) begin
      if (!NRST) begin
         ctrl_q     <= `TPW_CTRL_RESET;
         cmpa_buf_q <= 16'h0000;
         cmpb_buf_q <= 16'h0000;
         capt_q     <= 16'h0000;
      end else if (wr_acc) begin
         case (PADDR)
            `TPW_CTRL_OFF: ctrl_q <= {19'h00000, PWDATA[12:0]};
            `TPW_CMPA_OFF: cmpa_buf_q <= PWDATA[15:0] & res_mask(mode);
            `TPW_CMPB_OFF: cmpb_buf_q <= PWDATA[15:0] & res_mask(mode);
            `TPW_CAPT_OFF: capt_q <= PWDATA[15:0];
            default:       ctrl_q <= ctrl_q;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // APB read mux and handshake: no wait state, ready in the first access cycle
   // ------------------------------------------------------------------
   // Read data is latched in the setup cycle and stands until the next read
   always @* begin
      case (PADDR)
         `TPW_CTRL_OFF:     rd_d = ctrl_q;
         `TPW_CMPA_OFF:     rd_d = {16'h0000, cmpa_buf_q};
         `TPW_CMPB_OFF:     rd_d = {16'h0000, cmpb_buf_q};
         `TPW_CAPT_OFF:     rd_d = {16'h0000, capt_q};
         `TPW_CNT_OFF:      rd_d = {16'h0000, cnt_q};
         `TPW_FLAG_OFF:     rd_d = {28'h0000000, flag_q};
         `TPW_CMPA_ACT_OFF: rd_d = {16'h0000, cmpa_q};
         default:           rd_d = 32'h00000000;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (!NRST) begin
         PRDATA  <= 32'h00000000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & !PENABLE;
         PSLVERR <= PSEL & !PENABLE & !mapped;
         if (rd_set)
            PRDATA <= rd_d;
      end
   end

endmodule // tpw_timer

// *** test/tb_timer16_pwm_waveform_modes.sv ***
// Self-checking bench of the PWM timer with APB access
`timescale 1ns/1ns
`include "tpw_map.vh"
module tb_timer16_pwm_waveform_modes;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, oca, ocb, ena_n, enb_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   wire  [1:0]  pin;
   int          bad_count = 0;
   int          n_checks = 0;
   int          seed = 15;
   int          t;
   // Rows: mode, output mode, channel, TOP, compare B, prescale select
   int rows[20][6] = '{
      '{14,1,0,7,3,1}, '{15,1,0,3,2,1}, '{11,1,0,5,2,1}, '{14,2,1,7,2,1},
      '{14,3,1,7,2,1}, '{15,2,1,9,0,1}, '{14,2,1,6,6,1}, '{14,3,1,6,6,1},
      '{5,2,1,255,64,1}, '{10,2,1,7,3,1}, '{10,3,1,7,3,1}, '{11,2,1,8,0,1},
      '{11,3,1,8,8,1}, '{1,2,1,255,16,1}, '{2,2,1,511,256,1}, '{3,3,1,1023,512,1},
      '{8,2,1,12,5,1}, '{9,3,1,12,5,1}, '{10,2,1,7,9,1}, '{14,2,1,3,1,2}};
   int fixed_modes[6] = '{1, 2, 3, 5, 6, 7};

   // Clock of 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   tpw_timer dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .COMPARE_OUTPUT_A(oca), .COMPARE_OUTPUT_B(ocb), .PIN_ENABLE_A_N(ena_n), .PIN_ENABLE_B_N(enb_n));
   tpw_load u_load_a (.clk(clk), .level(oca), .en_n(ena_n), .pin(pin[0]));
   tpw_load u_load_b (.clk(clk), .level(ocb), .en_n(enb_n), .pin(pin[1]));

   // ----------------------------------------------------
   // Helpers
   // ----------------------------------------------------
   function automatic int xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed & 32'h7FFFFFFF;
   endfunction

   // High cycles seen over four counter periods
   function automatic int exp_high(int m, int om, int top, int cmp);
      bit dual = m inside {1, 2, 3, 8, 9, 10, 11};
      int p = dual ? 2 * top : top + 1;
      int h = dual ? 2 * cmp : (cmp == top ? p : top - cmp);
      if (om == 1) return (m == 15 || m == 11) ? 2 * p : 0;
      return 4 * (om == 3 ? p - h : h);
   endfunction

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask

   // One APB transfer, held until ready is sampled high or 20 access cycles pass
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("ready", 1, pready);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe, input string n);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(n, x, r);
      chk({n, " refusal"}, xe, e);
   endtask

   // Program one waveform, count high pin cycles, then check the flags
   task automatic run(input int m, input int om, input int ch, input int top, input int cmp, input int pre);
      int per = ((m inside {1, 2, 3, 8, 9, 10, 11}) ? 2 * top : top + 1) * (pre == 2 ? 8 : 1);
      int ctl = m | (om << (ch ? 6 : 4)) | (3 << 11);
      int h = 0;
      wr(`TPW_CTRL_OFF, ctl);
      wr(`TPW_CMPA_OFF, top);
      wr(`TPW_CAPT_OFF, top);
      wr(`TPW_CMPB_OFF, cmp);
      wr(`TPW_CNT_OFF, 32'h00000000);
      wr(`TPW_CTRL_OFF, ctl | (pre << 8));
      repeat (3 * per + 8) @(posedge clk);
      repeat (4 * per) begin
         @(posedge clk);
         h += pin[ch];
      end
      if (cmp <= top) begin
         chk("high count", exp_high(m, om, top, cmp) * (pre == 2 ? 8 : 1), h);
      end
      chk("pin enable", 0, ch ? enb_n : ena_n);
      wr(`TPW_FLAG_OFF, 32'h0000000F);
      repeat (per + 8) @(posedge clk);
      rd(`TPW_FLAG_OFF, ((m == 8 || m == 10 || m == 14) << 3) | ((cmp <= top) << 2) | 3, 0,
         "flags");
      rd(`TPW_CMPA_ACT_OFF, top, 0, "active compare");
   endtask

   task end_of_test;
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------------------
   // Main sequence
   // ----------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      nrst = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(`TPW_CTRL_OFF, `TPW_CTRL_RESET, 0, "control reset");
      rd(12'h01C, 32'h00000000, 1, "unmapped read");
      foreach (fixed_modes[i]) begin
         wr(`TPW_CTRL_OFF, fixed_modes[i]);
         wr(`TPW_CMPB_OFF, 32'h0000FFFF);
         rd(`TPW_CMPB_OFF, (32'h00000100 << (fixed_modes[i] % 4 - 1)) - 1, 0, "masked compare");
      end
      wr(`TPW_CTRL_OFF, 32'h0000000A);
      wr(`TPW_CMPB_OFF, 32'h0000FFFF);
      rd(`TPW_CMPB_OFF, 32'h0000FFFF, 0, "unmasked compare");
      foreach (rows[i]) begin
         run(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4], rows[i][5]);
      end
      // TOP changes from run to run, so the frequency correct mode is among the random runs
      for (int k = 0; k < 4; k++) begin
         t = 3 + xs() % 20;
         run(k % 2 ? 8 : 10, 2, 1, t, xs() % (t + 1), 1);
      end
      wr(`TPW_CTRL_OFF, 32'h0000018A);
      repeat (4) @(posedge clk);
      chk("pin enable off", 1, enb_n);
      end_of_test();
   end

   // Cut a hung run short
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
endmodule // tb_timer16_pwm_waveform_modes

// *** test/tpw_load.sv ***
// Model of a compare output pin with its external load
`timescale 1ns/1ns
module tpw_load (
   input  wire logic clk,
   input  wire logic level,
   input  wire logic en_n,
   output wire logic pin
);
   logic last_q = 1'b0;
   // An undriven pin has no pull: it shows the inverse of its last level
   assign pin = en_n ? ~last_q : level;
   // Remember the last driven level, so a released pin holds still
   always @(posedge clk) begin
      if (!en_n)
         last_q <= level;
   end
endmodule // tpw_load

// *** test/tpw_timer_assertions.sv ***
// Port-level assertions of the PWM timer
`timescale 1ns/1ns
`include "tpw_map.vh"
module tpw_timer_chk (
   input wire        REF_CLK,
   input wire        NRST,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire        COMPARE_OUTPUT_A,
   input wire        COMPARE_OUTPUT_B,
   input wire        PIN_ENABLE_A_N,
   input wire        PIN_ENABLE_B_N
);
   // ----------------------------------------------------
   // Bus answer and pin relations
   // ----------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // Setup cycle and out-of-map address decode
   wire setup = PSEL && !PENABLE;
   wire bad   = (PADDR > `TPW_CMPA_ACT_OFF) || (PADDR[1:0] != 2'h0);

   property p_answer; setup |=> PREADY && PSEL && PENABLE; endproperty
   a_answer: assert property (p_answer)
      else $error("ready missing one cycle after setup");
   property p_pulse; PREADY |=> !PREADY; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready held longer than one cycle");
   property p_err; PSLVERR |-> PREADY; endproperty
   a_err: assert property (p_err)
      else $error("error flag without ready");
   property p_unmap; setup && bad |=> PSLVERR; endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped address not refused");
   property p_map; setup && !bad |=> !PSLVERR; endproperty
   a_map: assert property (p_map)
      else $error("mapped address refused");
   property p_rst; $rose(NRST) |-> !COMPARE_OUTPUT_A && !COMPARE_OUTPUT_B && PIN_ENABLE_A_N && PIN_ENABLE_B_N;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not idle after reset");
   property p_pin;
      $changed({PIN_ENABLE_A_N, PIN_ENABLE_B_N}) |->
         $past(PSEL && PWRITE, 1) || $past(PSEL && PWRITE, 2) || $past(PSEL && PWRITE, 3);
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin enable moved without a register write");
   property p_rdata; $changed(PRDATA) |-> $past(PSEL && !PWRITE); endproperty
   a_rdata: assert property (p_rdata)
      else $error("read data moved outside a read");
endmodule // tpw_timer_chk

bind tpw_timer tpw_timer_chk u_chk (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A), .COMPARE_OUTPUT_B(COMPARE_OUTPUT_B),
   .PIN_ENABLE_A_N(PIN_ENABLE_A_N), .PIN_ENABLE_B_N(PIN_ENABLE_B_N));
